// ### hdl/audio_port_pkg.sv
package audio_port_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_POWER = 8'h01;
  localparam logic [7:0] REG_IRQ = 8'h02;
  localparam logic [7:0] REG_PA1 = 8'h03;
  localparam logic [7:0] REG_PA2 = 8'h04;
  localparam logic [7:0] REG_PB1 = 8'h05;
  // power register fields
  localparam int PW_CONV = 0;
  localparam int PW_RX = 1;
  localparam int PW_TX = 2;
  localparam int PW_PB = 3;
  localparam int PW_PA = 4;
  localparam int PW_ALL = 5;
  localparam int PW_RESET = 7;
  // port control one fields
  localparam int PC_FMT_LO = 0;
  localparam int PC_MODE = 3;
  localparam int PC_SEL_LO = 4;
  localparam int PC_MUTE = 6;
  // port A control two fields
  localparam int PC_DIV_LO = 0;
  localparam int PC_CLK_LO = 2;
  // writable masks and resets
  localparam logic [7:0] POWER_MASK = 8'h3F;
  localparam logic [7:0] PORT1_MASK = 8'h7F;
  localparam logic [7:0] PORT2_MASK = 8'h0F;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] PORT1_RST = 8'h00;
  localparam logic [7:0] PORT2_RST = 8'h00;
  // master clock figures
  localparam int DIV_BASE = 128;
  localparam int BCK_RATIO = 64;
  localparam int HALF_BASE = DIV_BASE / (2 * BCK_RATIO);
  localparam int HALF_W = 3;
  localparam int BCK_HALF_FRAME = BCK_RATIO / 2;
  localparam int BCK_CNT_W = 5;

  typedef enum logic [1:0] {
    OUT_OWN = 2'b00,
    OUT_OTHER = 2'b01,
    OUT_RX = 2'b10,
    OUT_CONV = 2'b11
  } out_sel_t;

  typedef enum logic [1:0] {
    MCLK_MAIN = 2'b00,
    MCLK_RX_IN = 2'b01,
    MCLK_RECOVERED = 2'b10,
    MCLK_RESERVED = 2'b11
  } mclk_sel_t;

  typedef enum logic [1:0] {
    JUST_LEFT = 2'b00,
    JUST_I2S = 2'b01,
    JUST_RIGHT = 2'b10,
    JUST_UNUSED = 2'b11
  } just_t;

  typedef struct packed {
    just_t just;
    logic [4:0] word_len;
  } fmt_t;

  typedef struct packed {
    logic serial_out;
    logic frame_out;
    logic frame_oe;
    logic bit_out;
    logic bit_oe;
  } port_pins_t;

  typedef struct packed {
    logic conv;
    logic rx;
    logic tx;
    logic port_a;
    logic port_b;
  } block_en_t;

  typedef struct packed {
    logic conv;
    logic rx;
    logic tx;
  } irq_t;

  typedef struct packed {
    logic own;
    logic other;
    logic rx;
    logic conv;
  } data_src_t;
endpackage : audio_port_pkg

// ### hdl/audio_port_power_control.sv
`timescale 1ns/100ps
module audio_port_power_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [audio_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [audio_port_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [audio_port_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire audio_port_pkg::irq_t irq_in,
  input wire logic main_master_clock,
  input wire logic receiver_clock_input,
  input wire logic recovered_receiver_clock,
  input wire audio_port_pkg::data_src_t port_a_data,
  input wire audio_port_pkg::data_src_t port_b_data,
  output audio_port_pkg::port_pins_t port_a_pins,
  output audio_port_pkg::port_pins_t port_b_pins,
  output audio_port_pkg::block_en_t block_enable,
  output audio_port_pkg::fmt_t port_a_format,
  output audio_port_pkg::fmt_t port_b_format,
  output logic soft_reset_pulse
);
  import audio_port_pkg::*;

  logic rst_meta_r;
  logic rst_sync_r;
  logic [7:0] power_r;
  logic [7:0] pa_one_r;
  logic [7:0] pa_two_r;
  logic [7:0] pb_one_r;
  logic srst_r;
  logic mclk_q_r;
  logic mclk_sel;
  logic mclk_edge;
  logic [HALF_W-1:0] half_cnt_r;
  logic [HALF_W-1:0] half_len;
  logic [BCK_CNT_W-1:0] bck_cnt_r;
  logic bck_r;
  logic frame_clock_r;
  logic gen_run;
  logic a_en;
  logic b_en;
  logic a_master;
  logic b_master;

  function automatic fmt_t decode_fmt(input logic [2:0] code);
    fmt_t f;
    f.just = JUST_RIGHT;
    f.word_len = 5'd24;
    case (code)
      3'b000: begin
        f.just = JUST_LEFT;
      end
      3'b001: begin
        f.just = JUST_I2S;
      end
      3'b010, 3'b011: begin
        f.just = JUST_UNUSED;
      end
      3'b100: begin
        f.word_len = 5'd16;
      end
      3'b101: begin
        f.word_len = 5'd18;
      end
      3'b110: begin
        f.word_len = 5'd20;
      end
      default: begin
        f.word_len = 5'd24;
      end
    endcase
    return f;
  endfunction : decode_fmt

  function automatic logic pick_src(input logic [1:0] sel, input data_src_t d);
    logic v;
    v = 1'b0;
    case (out_sel_t'(sel))
      OUT_OWN: v = d.own;
      OUT_OTHER: v = d.other;
      OUT_RX: v = d.rx;
      OUT_CONV: v = d.conv;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pick_src

  // reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // software reset request, self clearing
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= reg_wr && reg_addr == REG_POWER && reg_wdata[PW_RESET];
    end
  end

  // control registers
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      power_r <= POWER_RST;
      pa_one_r <= PORT1_RST;
      pa_two_r <= PORT2_RST;
      pb_one_r <= PORT1_RST;
    end else if (srst_r) begin
      power_r <= POWER_RST;
      pa_one_r <= PORT1_RST;
      pa_two_r <= PORT2_RST;
      pb_one_r <= PORT1_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_POWER: begin
          power_r <= reg_wdata & POWER_MASK;
        end
        REG_PA1: begin
          pa_one_r <= reg_wdata & PORT1_MASK;
        end
        REG_PA2: begin
          pa_two_r <= reg_wdata & PORT2_MASK;
        end
        REG_PB1: begin
          pb_one_r <= reg_wdata & PORT1_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // register reads
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          REG_POWER: reg_rdata <= power_r;
          REG_IRQ: reg_rdata <= {5'h00, irq_in.tx, irq_in.rx, irq_in.conv};
          REG_PA1: reg_rdata <= pa_one_r;
          REG_PA2: reg_rdata <= pa_two_r;
          REG_PB1: reg_rdata <= pb_one_r;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  assign a_en = power_r[PW_ALL] & power_r[PW_PA];
  assign b_en = power_r[PW_ALL] & power_r[PW_PB];
  assign a_master = pa_one_r[PC_MODE];
  assign b_master = pb_one_r[PC_MODE];
  assign gen_run = (a_master & a_en) | (b_master & b_en);

  // master clock source select
  always_comb begin
    case (mclk_sel_t'(pa_two_r[PC_CLK_LO +: 2]))
      MCLK_MAIN: mclk_sel = main_master_clock;
      MCLK_RX_IN: mclk_sel = receiver_clock_input;
      MCLK_RECOVERED: mclk_sel = recovered_receiver_clock;
      default: mclk_sel = 1'b0;
    endcase
  end

  assign mclk_edge = mclk_sel & ~mclk_q_r;
  assign half_len = HALF_W'(HALF_BASE) * (HALF_W'(pa_two_r[PC_DIV_LO +: 2]) + 3'd1);

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mclk_q_r <= 1'b0;
    end else begin
      mclk_q_r <= mclk_sel;
    end
  end

  // bit clock: half period of 1..4 master clock edges
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      half_cnt_r <= '0;
      bck_r <= 1'b0;
    end else if (!gen_run) begin
      half_cnt_r <= '0;
      bck_r <= 1'b0;
    end else if (mclk_edge) begin
      if (half_cnt_r == half_len - 3'd1) begin
        half_cnt_r <= '0;
        bck_r <= ~bck_r;
      end else begin
        half_cnt_r <= half_cnt_r + 3'd1;
      end
    end
  end

  // frame clock: toggles every 32 bit clock periods
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      bck_cnt_r <= '0;
      frame_clock_r <= 1'b0;
    end else if (!gen_run) begin
      bck_cnt_r <= '0;
      frame_clock_r <= 1'b0;
    end else if (mclk_edge && bck_r && half_cnt_r == half_len - 3'd1) begin
      if (bck_cnt_r == BCK_CNT_W'(BCK_HALF_FRAME - 1)) begin
        bck_cnt_r <= '0;
        frame_clock_r <= ~frame_clock_r;
      end else begin
        bck_cnt_r <= bck_cnt_r + 5'd1;
      end
    end
  end

  // port A pins
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      port_a_pins <= '0;
    end else begin
      port_a_pins.serial_out <= a_en & ~pa_one_r[PC_MUTE]
        & pick_src(pa_one_r[PC_SEL_LO +: 2], port_a_data);
      port_a_pins.frame_out <= a_en & a_master & frame_clock_r;
      port_a_pins.bit_out <= a_en & a_master & bck_r;
      port_a_pins.frame_oe <= a_master;
      port_a_pins.bit_oe <= a_master;
    end
  end

  // port B pins, master clocks from the port A generator
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      port_b_pins <= '0;
    end else begin
      port_b_pins.serial_out <= b_en & ~pb_one_r[PC_MUTE]
        & pick_src(pb_one_r[PC_SEL_LO +: 2], port_b_data);
      port_b_pins.frame_out <= b_en & b_master & frame_clock_r;
      port_b_pins.bit_out <= b_en & b_master & bck_r;
      port_b_pins.frame_oe <= b_master;
      port_b_pins.bit_oe <= b_master;
    end
  end

  // block enables and formats
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      block_enable <= '0;
      port_a_format <= decode_fmt(3'b000);
      port_b_format <= decode_fmt(3'b000);
      soft_reset_pulse <= 1'b0;
    end else begin
      block_enable.conv <= power_r[PW_ALL] & power_r[PW_CONV];
      block_enable.rx <= power_r[PW_ALL] & power_r[PW_RX];
      block_enable.tx <= power_r[PW_ALL] & power_r[PW_TX];
      block_enable.port_a <= a_en;
      block_enable.port_b <= b_en;
      port_a_format <= decode_fmt(pa_one_r[PC_FMT_LO +: 3]);
      port_b_format <= decode_fmt(pb_one_r[PC_FMT_LO +: 3]);
      soft_reset_pulse <= srst_r;
    end
  end
endmodule : audio_port_power_control

// ### dv/audio_port_props.sv
`timescale 1ns/100ps
module audio_port_props
  import audio_port_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire audio_port_pkg::irq_t irq_in,
  input wire audio_port_pkg::port_pins_t port_a_pins,
  input wire audio_port_pkg::port_pins_t port_b_pins,
  input wire audio_port_pkg::block_en_t block_enable,
  input wire audio_port_pkg::fmt_t port_a_format,
  input wire audio_port_pkg::fmt_t port_b_format,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_only_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("stray read answer");
  irq_read_a: assert property (reg_rd && reg_addr == 8'h02 |=>
    reg_rdata == {5'h00, $past(irq_in.tx), $past(irq_in.rx), $past(irq_in.conv)})
    else $error("summary read wrong");
  a_off_low_a: assert property (!block_enable.port_a && $past(!block_enable.port_a) |->
    !port_a_pins.serial_out && !port_a_pins.frame_out && !port_a_pins.bit_out)
    else $error("port A active while off");
  b_off_low_a: assert property (!block_enable.port_b && $past(!block_enable.port_b) |->
    !port_b_pins.serial_out && !port_b_pins.frame_out && !port_b_pins.bit_out)
    else $error("port B active while off");
  a_oe_pair_a: assert property (port_a_pins.frame_oe == port_a_pins.bit_oe)
    else $error("port A clock enables differ");
  b_oe_pair_a: assert property (port_b_pins.frame_oe == port_b_pins.bit_oe)
    else $error("port B clock enables differ");
  fmt_legal_a: assert property ((port_a_format.just == JUST_RIGHT ||
    port_a_format.word_len == 5'h18) && (port_b_format.just == JUST_RIGHT || port_b_format.word_len == 5'h18))
    else $error("format length wrong");
  srst_pulse_a: assert property (soft_reset_pulse |=>
    !soft_reset_pulse ##[0:2] block_enable == 5'h00)
    else $error("soft reset pulse wrong");
  frame_edge_a: assert property (port_a_pins.frame_oe && $past(port_a_pins.frame_oe) &&
    block_enable.port_a && $past(block_enable.port_a) && $changed(port_a_pins.frame_out)
    |-> $fell(port_a_pins.bit_out))
    else $error("frame moved off bit edge");
  cover property (reg_rd && reg_addr == 8'h02);
  cover property ($rose(port_a_pins.bit_out));
  cover property (soft_reset_pulse);
endmodule : audio_port_props

bind audio_port_power_control audio_port_props u_props (.clk, .nrst, .reg_addr, .reg_rd, .reg_rdata,
  .reg_rvalid, .irq_in, .port_a_pins, .port_b_pins, .block_enable, .port_a_format, .port_b_format,
  .soft_reset_pulse);

// ### dv/audio_far_side.sv
`timescale 1ns/100ps
module audio_far_side (
  input wire logic clk,
  input wire logic [3:0] pat_a,
  input wire logic [3:0] pat_b,
  output audio_port_pkg::data_src_t port_a_data,
  output audio_port_pkg::data_src_t port_b_data,
  output logic mclk_main,
  output logic mclk_rxi,
  output logic mclk_rec
);
  import audio_port_pkg::*;
  logic [3:0] cnt_r = 4'h0;
  // free-running master clocks, periods 4, 8, 16 clk
  always @(negedge clk) cnt_r <= cnt_r + 4'h1;
  assign mclk_main = cnt_r[1];
  assign mclk_rxi = cnt_r[2];
  assign mclk_rec = cnt_r[3];
  // serial words chosen by the bench
  assign port_a_data = pat_a;
  assign port_b_data = pat_b;
endmodule : audio_far_side

// ### dv/audio_port_power_control_tb_top.sv
`timescale 1ns/100ps
module audio_port_power_control_tb_top;
  import audio_port_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, d;
  logic [3:0] pat_a = 4'h0;
  logic [3:0] pat_b = 4'h0;
  logic reg_rvalid, mm, mr, mc, srp;
  irq_t irq_in = 3'h0;
  data_src_t pa_d, pb_d;
  port_pins_t pa, pb;
  block_en_t en;
  fmt_t fa, fb;
  int n_fail = 0;
  int n_tests = 0;
  int i, j, n;
  int n_srp = 0;
  logic [7:0] pw[6] = '{8'h1F, 8'h24, 8'h30, 8'h28, 8'h21, 8'h22};
  logic [4:0] pe[6] = '{5'h00, 5'h04, 5'h02, 5'h01, 5'h10, 5'h08};
  logic [7:0] msk[6] = '{8'h00, 8'h3F, 8'h00, 8'h7F, 8'h0F, 8'h7F};
  logic [7:0] ck[4] = '{8'h00, 8'h03, 8'h06, 8'h09};
  always #5 clk = ~clk;
  // count cycles in which the soft reset pulse stands
  always @(negedge clk) if (srp === 1'b1) n_srp++;
  audio_far_side far (.clk, .pat_a, .pat_b, .port_a_data(pa_d), .port_b_data(pb_d),
    .mclk_main(mm), .mclk_rxi(mr), .mclk_rec(mc));
  audio_port_power_control dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .irq_in, .main_master_clock(mm), .receiver_clock_input(mr), .recovered_receiver_clock(mc),
    .port_a_data(pa_d), .port_b_data(pb_d), .port_a_pins(pa), .port_b_pins(pb), .block_enable(en),
    .port_a_format(fa), .port_b_format(fb), .soft_reset_pulse(srp));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    chk(reg_rvalid, 1'b1);
  endtask : rd
  task span(input bit f, input bit b);
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (((f ? (b ? pb.frame_out : pa.frame_out) : (b ? pb.bit_out : pa.bit_out)) === k[0]) && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
  endtask : span
  function automatic logic [7:0] fexp(input logic [2:0] c);
    if (c[2]) return {1'b0, JUST_RIGHT, (c[1:0] == 2'h3) ? 5'h18 : 5'h10 + {2'h0, c[1:0], 1'b0}};
    return {1'b0, c[1] ? JUST_UNUSED : (c[0] ? JUST_I2S : JUST_LEFT), 5'h18};
  endfunction : fexp
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 7; i++) begin
      rd(i[7:0]);
      chk(d, 8'h00);
    end
    chk(fa, 8'h18);
    chk(fb, 8'h18);
    for (i = 1; i < 6; i++) wr(i[7:0], (i == 1) ? 8'h7F : 8'hFF);
    for (i = 1; i < 6; i++) begin
      rd(i[7:0]);
      chk(d, msk[i]);
    end
    chk(en, 5'h1F);
    wr(8'h01, 8'hBF);
    chk(n_srp, 16'h1);
    for (i = 1; i < 6; i++) begin
      rd(i[7:0]);
      chk(d, 8'h00);
    end
    for (i = 0; i < 6; i++) begin
      wr(8'h01, pw[i]);
      chk(en, pe[i]);
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h03, i[7:0]);
      wr(8'h05, i[7:0]);
      chk(fa, fexp(i[2:0]));
      chk(fb, fexp(i[2:0]));
    end
    wr(8'h01, 8'h38);
    for (j = 0; j < 2; j++) for (i = 0; i < 4; i++) begin
      pat_a = 4'h8 >> i;
      pat_b = 4'h8 >> i;
      wr(8'h03, {1'b0, j[0], i[1:0], 4'h0});
      wr(8'h05, {1'b0, j[0], i[1:0], 4'h0});
      chk(pa.serial_out, !j[0]);
      chk(pb.serial_out, !j[0]);
      pat_a = ~pat_a;
      pat_b = ~pat_b;
      repeat (3) @(negedge clk);
      chk({pa.serial_out, pb.serial_out}, 2'h0);
    end
    pat_a = 4'h8;
    pat_b = 4'h8;
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h01, 8'h20);
    chk({pa.serial_out, pb.serial_out}, 2'h0);
    wr(8'h01, 8'h30);
    wr(8'h03, 8'h08);
    chk({pa.frame_oe, pa.bit_oe}, 2'h3);
    for (i = 0; i < 4; i++) begin
      wr(8'h04, ck[i]);
      span(1'b0, 1'b0);
      chk(n, (16'h4 << ck[i][3:2]) * (ck[i][1:0] + 16'h1));
    end
    wr(8'h04, 8'h00);
    span(1'b1, 1'b0);
    chk(n, 16'h100);
    wr(8'h03, 8'h00);
    chk({pa.frame_oe, pa.bit_oe}, 2'h0);
    wr(8'h04, 8'h0C);
    wr(8'h03, 8'h08);
    span(1'b0, 1'b0);
    chk(n, 16'h0);
    wr(8'h05, 8'h08);
    wr(8'h01, 8'h28);
    chk({pb.frame_oe, pb.bit_oe}, 2'h3);
    wr(8'h04, 8'h00);
    span(1'b0, 1'b1);
    chk(n, 16'h4);
    span(1'b1, 1'b1);
    chk(n, 16'h100);
    for (i = 0; i < 8; i++) begin
      irq_in = i[2:0];
      rd(8'h02);
      chk(d, {5'h00, i[0], i[1], i[2]});
    end
    print_verdict();
  end
endmodule : audio_port_power_control_tb_top
